// ### rtl/msu_cfg.svh
// msu_cfg.svh: register indices, storage slots, control bits and constants
// assumes: included by bare name by msu_cordic, msu_arith, msu_top and tb_top
`ifndef MSU_CFG_SVH
`define MSU_CFG_SVH

// register indices; the byte address on the bus is four times the index
`define MSU_IX_ANGLE    12'h32c
`define MSU_IX_RES1     12'h32e
`define MSU_IX_RES2     12'h330
`define MSU_IX_F3_GAIN  12'h398
`define MSU_IX_F3_IN    12'h39a
`define MSU_IX_F3_ST    12'h39c
`define MSU_IX_F2_GAIN  12'h3a0
`define MSU_IX_F2_IN    12'h3a2
`define MSU_IX_F2_ST    12'h3a4
`define MSU_IX_L0_KP    12'h3e0
`define MSU_IX_L0_EK1   12'h3e2
`define MSU_IX_L0_EK    12'h3e4
`define MSU_IX_L0_KI    12'h3e6
`define MSU_IX_L0_UH    12'h3e8
`define MSU_IX_L0_UL    12'h3ea
`define MSU_IX_L0_MAX   12'h3ec
`define MSU_IX_L0_MIN   12'h3ee
`define MSU_IX_F1_GAIN  12'h3f0
`define MSU_IX_F1_IN    12'h3f2
`define MSU_IX_F1_ST    12'h3f4
`define MSU_IX_F0_GAIN  12'h3f8
`define MSU_IX_F0_IN    12'h3fa
`define MSU_IX_F0_ST    12'h3fc
`define MSU_IX_CTL      12'h300
`define MSU_IX_STAT     12'h302

// storage slots of 16 bits; a filter owns gain, input, state high, state low
`define MSU_NSLOT       27
`define MSU_S_ANGLE     5'd0
`define MSU_S_RES1      5'd1
`define MSU_S_RES2      5'd2
`define MSU_S_F0        5'd3
`define MSU_S_F1        5'd7
`define MSU_S_F2        5'd11
`define MSU_S_F3        5'd15
`define MSU_S_KP        5'd19
`define MSU_S_EK1       5'd20
`define MSU_S_EK        5'd21
`define MSU_S_KI        5'd22
`define MSU_S_UH        5'd23
`define MSU_S_UL        5'd24
`define MSU_S_MAX       5'd25
`define MSU_S_MIN       5'd26

// control word bits
`define MSU_CTL_TRIG    0
`define MSU_CTL_MODE    1
`define MSU_CTL_FILT    2
`define MSU_CTL_LOOP    6

`define MSU_RST_VAL     16'h0000
`define MSU_CORDIC_GAIN 16'h4dba
`define MSU_CORDIC_ITER 4'd15
`define MSU_JOB_LOOP    3'd4

`endif

// ### rtl/msu_pkg.sv
// msu_pkg: types shared by the math unit register bank
// assumes: nothing beyond a SystemVerilog compiler
package msu_pkg;
	typedef enum logic       {MSU_SEQ_IDLE, MSU_SEQ_RUN} msu_seq_t;
	typedef enum logic [1:0] {MSU_CD_IDLE, MSU_CD_ITER, MSU_CD_SCALE} msu_cd_t;
endpackage

// ### rtl/msu_cordic.sv
// msu_cordic: iterative rotation/vectoring engine for the trig unit
// assumes: pclk domain, start only while idle, angle full scale = +-pi
`include "msu_cfg.svh"
module msu_cordic import msu_pkg::*; (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        start,
	input  wire logic        atan_mode,
	input  wire logic [15:0] angle,
	input  wire logic [15:0] x_in,
	input  wire logic [15:0] y_in,
	output logic             busy,
	output logic             done,
	output logic [15:0]      out_one,
	output logic [15:0]      out_two
);
	msu_cd_t            st_q;
	logic               mode_q;
	logic [3:0]         i_q;
	logic signed [19:0] x_q, y_q, xs, ys;
	logic [15:0]        z_q, step;
	logic signed [36:0] mag;
	wire                neg = mode_q ? ~y_q[19] : z_q[15];
	wire                flip = angle[15] ^ angle[14];

	// arctangent of 2^-i, pi = 16'h8000
	function automatic logic [15:0] atan_lut(input logic [3:0] i);
		case (i)
			4'd0: atan_lut = 16'h2000;
			4'd1: atan_lut = 16'h12e4;
			4'd2: atan_lut = 16'h09fb;
			4'd3: atan_lut = 16'h0511;
			4'd4: atan_lut = 16'h028b;
			4'd5: atan_lut = 16'h0146;
			4'd6: atan_lut = 16'h00a3;
			4'd7: atan_lut = 16'h0051;
			4'd8: atan_lut = 16'h0029;
			4'd9: atan_lut = 16'h0014;
			4'd10: atan_lut = 16'h000a;
			4'd11: atan_lut = 16'h0005;
			4'd12, 4'd13: atan_lut = 16'h0003 >> (i - 4'd12 + 4'd0) | 16'h0001;
			default: atan_lut = 16'h0001;
		endcase
	endfunction

	// clip a wide product or coordinate to a signed half word
	function automatic logic [15:0] sat16(input logic signed [36:0] v);
		if (v > 37'sd32767)
			sat16 = 16'h7fff;
		else if (v < -37'sd32768)
			sat16 = 16'h8000;
		else
			sat16 = v[15:0];
	endfunction

	assign xs   = x_q >>> i_q;
	assign ys   = y_q >>> i_q;
	assign step = atan_lut(i_q);
	assign mag  = 37'(x_q) * 37'($signed({4'h0, `MSU_CORDIC_GAIN}));
	assign busy = (st_q != MSU_CD_IDLE);

	// one micro-rotation per clock; quadrant folded in before the first
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= MSU_CD_IDLE;
			mode_q <= 1'b0;
			i_q <= 4'h0;
			x_q <= 20'sh0;
			y_q <= 20'sh0;
			z_q <= 16'h0;
			done <= 1'b0;
			out_one <= `MSU_RST_VAL;
			out_two <= `MSU_RST_VAL;
		end else begin
			done <= 1'b0;
			case (st_q)
				MSU_CD_IDLE: if (start) begin
					mode_q <= atan_mode;
					i_q <= 4'h0;
					st_q <= MSU_CD_ITER;
					if (atan_mode) begin
						x_q <= x_in[15] ? -20'(signed'(x_in)) : 20'(signed'(x_in));
						y_q <= x_in[15] ? -20'(signed'(y_in)) : 20'(signed'(y_in));
						z_q <= x_in[15] ? 16'h8000 : 16'h0;
					end else begin
						x_q <= flip ? -20'(signed'(`MSU_CORDIC_GAIN)) : 20'(`MSU_CORDIC_GAIN);
						y_q <= 20'sh0;
						z_q <= flip ? angle ^ 16'h8000 : angle;
					end
				end
				MSU_CD_ITER: begin
					x_q <= neg ? x_q + ys : x_q - ys;
					y_q <= neg ? y_q - xs : y_q + xs;
					z_q <= neg ? z_q + step : z_q - step;
					i_q <= i_q + 4'h1;
					if (i_q == `MSU_CORDIC_ITER - 4'h1)
						st_q <= MSU_CD_SCALE;
				end
				MSU_CD_SCALE: begin
					out_one <= mode_q ? sat16(mag >>> 15) : sat16(37'(x_q));
					out_two <= mode_q ? z_q : sat16(37'(y_q));
					done <= 1'b1;
					st_q <= MSU_CD_IDLE;
				end
				default: st_q <= MSU_CD_IDLE;
			endcase
		end
	end
endmodule // msu_cordic

// ### rtl/msu_arith.sv
// msu_arith: one-cycle filter and proportional-integral step
// assumes: pclk domain, operands stable in the cycle start is high
`include "msu_cfg.svh"
module msu_arith (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        start,
	input  wire logic        loop_op,
	input  wire logic [15:0] coef_a,
	input  wire logic [15:0] coef_b,
	input  wire logic [15:0] now,
	input  wire logic [15:0] prev,
	input  wire logic [31:0] acc,
	input  wire logic [15:0] ceil,
	input  wire logic [15:0] floor_v,
	output logic             done,
	output logic [31:0]      result
);
	logic signed [16:0] d_f, d_l;
	logic signed [33:0] p_f, p_l, p_i;
	logic        [31:0] sum;
	logic        [31:0] clamped;

	// filter: y += k*(x - y_hi); loop: u += kp*(e - e1) + ki*e, all Q15
	assign d_f = 17'(signed'(now)) - 17'(signed'(acc[31:16]));
	assign d_l = 17'(signed'(now)) - 17'(signed'(prev));
	// operands widened first so the full signed product survives
	assign p_f = 34'(signed'(coef_a)) * 34'(d_f);
	assign p_l = 34'(signed'(coef_a)) * 34'(d_l);
	assign p_i = 34'(signed'(coef_b)) * 34'(signed'(now));
	assign sum = acc + (loop_op ? 32'((p_l + p_i) <<< 1) : 32'(p_f <<< 1));

	// ceiling checked first; with crossed limits a sum above the ceiling pins there, any other to the floor
	assign clamped = (signed'(sum[31:16]) > signed'(ceil)) ? {ceil, 16'h0} :
	                 (signed'(sum[31:16]) < signed'(floor_v)) ? {floor_v, 16'h0} : sum;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			done <= 1'b0;
			result <= 32'h0;
		end else begin
			done <= start;
			if (start)
				result <= loop_op ? clamped : sum;
		end
	end
endmodule // msu_arith

// ### rtl/msu_top.sv
// msu_top: operand and result register bank for the trig, filter and loop units
// assumes: APB master on pclk, one 16- or 32-bit register per aligned word
//
// Overview of operation
// - trig unit reads its angle from the angle input in sine/cosine mode
// - result one gets cosine, or vector magnitude in arctangent mode
// - result two gets sine, or the computed angle in arctangent mode
// - filter 0 state holds previous output, then the new output
// - filter 1 state holds previous output, then the new output
// - filter 2 state holds previous output, then the new output
// - filter 3 state holds previous output, then the new output
// - loop 0 uses proportional and integral gain registers as coefficients
// - loop 0 keeps previous error in a readable, writable register
// - loop 0 takes present error from a register software writes
// - loop 0 output is 32 bits split across high and low registers
// - loop 0 output is clamped to programmable ceiling and floor
`include "msu_cfg.svh"
module msu_top import msu_pkg::*; #(
	parameter int ADDR_W = 14
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	input  wire logic [3:0]        pstrb,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr
);
	localparam int NSLOT = `MSU_NSLOT;

	// ****************************************************************
	// address decode
	// ****************************************************************

	// {hit, wide, slot}: wide registers cover the high and next slot
	function automatic logic [6:0] decode(input logic [11:0] ix);
		case (ix)
			`MSU_IX_ANGLE:   decode = {2'b10, `MSU_S_ANGLE};
			`MSU_IX_RES1:    decode = {2'b10, `MSU_S_RES1};
			`MSU_IX_RES2:    decode = {2'b10, `MSU_S_RES2};
			`MSU_IX_F0_GAIN: decode = {2'b10, `MSU_S_F0};
			`MSU_IX_F0_IN:   decode = {2'b10, `MSU_S_F0 + 5'd1};
			`MSU_IX_F0_ST:   decode = {2'b11, `MSU_S_F0 + 5'd2};
			`MSU_IX_F1_GAIN: decode = {2'b10, `MSU_S_F1};
			`MSU_IX_F1_IN:   decode = {2'b10, `MSU_S_F1 + 5'd1};
			`MSU_IX_F1_ST:   decode = {2'b11, `MSU_S_F1 + 5'd2};
			`MSU_IX_F2_GAIN: decode = {2'b10, `MSU_S_F2};
			`MSU_IX_F2_IN:   decode = {2'b10, `MSU_S_F2 + 5'd1};
			`MSU_IX_F2_ST:   decode = {2'b11, `MSU_S_F2 + 5'd2};
			`MSU_IX_F3_GAIN: decode = {2'b10, `MSU_S_F3};
			`MSU_IX_F3_IN:   decode = {2'b10, `MSU_S_F3 + 5'd1};
			`MSU_IX_F3_ST:   decode = {2'b11, `MSU_S_F3 + 5'd2};
			`MSU_IX_L0_KP:   decode = {2'b10, `MSU_S_KP};
			`MSU_IX_L0_EK1:  decode = {2'b10, `MSU_S_EK1};
			`MSU_IX_L0_EK:   decode = {2'b10, `MSU_S_EK};
			`MSU_IX_L0_KI:   decode = {2'b10, `MSU_S_KI};
			`MSU_IX_L0_UH:   decode = {2'b10, `MSU_S_UH};
			`MSU_IX_L0_UL:   decode = {2'b10, `MSU_S_UL};
			`MSU_IX_L0_MAX:  decode = {2'b10, `MSU_S_MAX};
			`MSU_IX_L0_MIN:  decode = {2'b10, `MSU_S_MIN};
			default:         decode = 7'h0;
		endcase
	endfunction

	logic [15:0] regs_q [NSLOT];
	logic [NSLOT-1:0] hw_we;
	logic [15:0] hw_wd [NSLOT];
	logic        pready_q, pslverr_q, mode_q, cor_busy, cor_done, ar_done;
	logic [31:0] prdata_q, rd_data, ar_res;
	logic [15:0] cor_one, cor_two;
	logic [4:0]  pend_q, pend_d, run_mask;
	logic [2:0]  job_q, pick;
	logic        pick_any;
	msu_seq_t    seq_q;

	wire [11:0] reg_ix   = paddr[13:2];
	wire [6:0]  dec      = decode(reg_ix);
	wire        hit      = dec[6];
	wire        wide     = dec[5];
	wire [4:0]  slot     = dec[4:0];
	wire [4:0]  slot_lo  = slot + 5'd1;
	wire        ctl_hit  = (reg_ix == `MSU_IX_CTL);
	wire        stat_hit = (reg_ix == `MSU_IX_STAT);
	wire        setup    = psel & ~penable;
	wire        wr       = psel & penable & pready_q & pwrite;
	wire        ctl_wr   = wr & ctl_hit & pstrb[0];
	wire        trig_go  = ctl_wr & pwdata[`MSU_CTL_TRIG] & ~cor_busy;
	wire        loop_job = (job_q == `MSU_JOB_LOOP);
	wire [4:0]  fbase    = `MSU_S_F0 + {job_q[1:0], 2'b00};
	wire        ar_go    = (seq_q == MSU_SEQ_IDLE) & pick_any;

	// ****************************************************************
	// register storage
	// ****************************************************************

	// per-slot merge: hardware result first, software byte lanes on top
	for (genvar s = 0; s < NSLOT; s++) begin : g_slot
		wire         sel_hi = wr & hit & wide & (slot == 5'(s));
		wire         sel_lo = wr & hit & (wide ? (slot_lo == 5'(s)) : (slot == 5'(s)));
		logic [15:0] d;
		always_comb begin
			d = hw_we[s] ? hw_wd[s] : regs_q[s];
			if (sel_hi) begin
				if (pstrb[3]) d[15:8] = pwdata[31:24];
				if (pstrb[2]) d[7:0] = pwdata[23:16];
			end
			if (sel_lo) begin
				if (pstrb[1]) d[15:8] = pwdata[15:8];
				if (pstrb[0]) d[7:0] = pwdata[7:0];
			end
		end
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn)
				regs_q[s] <= `MSU_RST_VAL;
			else
				regs_q[s] <= d;
		end
	end

	// ****************************************************************
	// bus answer
	// ****************************************************************

	// high half of a wide register lands in the upper lanes of the word
	always_comb begin
		rd_data = 32'h0;
		if (ctl_hit)
			rd_data[`MSU_CTL_MODE] = mode_q;
		else if (stat_hit)
			rd_data[5:0] = {pend_q | run_mask, cor_busy};
		else if (hit && wide)
			rd_data = {regs_q[slot], regs_q[slot_lo]};
		else if (hit)
			rd_data[15:0] = regs_q[slot];
	end

	// one wait-free access phase: answer is registered during setup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0;
		end else begin
			pready_q <= setup;
			pslverr_q <= setup & ~(hit | ctl_hit | stat_hit);
			prdata_q <= (setup & ~pwrite) ? rd_data : 32'h0;
		end
	end
	assign pready  = pready_q;
	assign pslverr = pslverr_q;
	assign prdata  = prdata_q;

	// ****************************************************************
	// control and job sequencing
	// ****************************************************************

	// lowest pending job first; loop job is index four
	always_comb begin
		pick = 3'd0;
		pick_any = 1'b0;
		for (int k = 4; k >= 0; k--) begin
			if (pend_q[k]) begin
				pick = 3'(k);
				pick_any = 1'b1;
			end
		end
	end

	// a request landing on the cycle its own bit is taken is kept
	assign pend_d   = (pend_q & ~(ar_go ? (5'h1 << pick) : 5'h0)) |
	                  (ctl_wr ? pwdata[`MSU_CTL_LOOP:`MSU_CTL_FILT] : 5'h0);
	assign run_mask = (seq_q == MSU_SEQ_RUN) ? (5'h1 << job_q) : 5'h0;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_q <= 1'b0;
			pend_q <= 5'h0;
			job_q <= 3'd0;
			seq_q <= MSU_SEQ_IDLE;
		end else begin
			pend_q <= pend_d;
			if (ctl_wr)
				mode_q <= pwdata[`MSU_CTL_MODE];
			case (seq_q)
				MSU_SEQ_IDLE: if (pick_any) begin
					job_q <= pick;
					seq_q <= MSU_SEQ_RUN;
				end
				MSU_SEQ_RUN: if (ar_done)
					seq_q <= MSU_SEQ_IDLE;
				default: seq_q <= MSU_SEQ_IDLE;
			endcase
		end
	end

	// ****************************************************************
	// compute units
	// ****************************************************************

	// arctangent mode takes its vector from the two result registers
	msu_cordic u_cordic (
		.pclk      (pclk),
		.presetn   (presetn),
		.start     (trig_go),
		.atan_mode (pwdata[`MSU_CTL_MODE]),
		.angle     (regs_q[`MSU_S_ANGLE]),
		.x_in      (regs_q[`MSU_S_RES1]),
		.y_in      (regs_q[`MSU_S_RES2]),
		.busy      (cor_busy),
		.done      (cor_done),
		.out_one   (cor_one),
		.out_two   (cor_two)
	);

	// operands come from the job picked this cycle, held by the bank
	wire [2:0] jsel = ar_go ? pick : job_q;
	wire [4:0] jb   = `MSU_S_F0 + {jsel[1:0], 2'b00};
	wire       jlp  = (jsel == `MSU_JOB_LOOP);

	msu_arith u_arith (
		.pclk    (pclk),
		.presetn (presetn),
		.start   (ar_go),
		.loop_op (jlp),
		.coef_a  (jlp ? regs_q[`MSU_S_KP] : regs_q[jb]),
		.coef_b  (regs_q[`MSU_S_KI]),
		.now     (jlp ? regs_q[`MSU_S_EK] : regs_q[jb + 5'd1]),
		.prev    (regs_q[`MSU_S_EK1]),
		.acc     (jlp ? {regs_q[`MSU_S_UH], regs_q[`MSU_S_UL]} :
		                {regs_q[jb + 5'd2], regs_q[jb + 5'd3]}),
		.ceil    (regs_q[`MSU_S_MAX]),
		.floor_v (regs_q[`MSU_S_MIN]),
		.done    (ar_done),
		.result  (ar_res)
	);

	// results written back by hardware; bus bytes of the same cycle win
	always_comb begin
		hw_we = '0;
		for (int k = 0; k < NSLOT; k++)
			hw_wd[k] = 16'h0;
		if (cor_done) begin
			hw_we[`MSU_S_RES1] = 1'b1;
			hw_wd[`MSU_S_RES1] = cor_one;
			hw_we[`MSU_S_RES2] = 1'b1;
			hw_wd[`MSU_S_RES2] = cor_two;
		end
		if (ar_done && loop_job) begin
			hw_we[`MSU_S_UH] = 1'b1;
			hw_wd[`MSU_S_UH] = ar_res[31:16];
			hw_we[`MSU_S_UL] = 1'b1;
			hw_wd[`MSU_S_UL] = ar_res[15:0];
			hw_we[`MSU_S_EK1] = 1'b1;
			hw_wd[`MSU_S_EK1] = regs_q[`MSU_S_EK];
		end else if (ar_done) begin
			hw_we[fbase + 5'd2] = 1'b1;
			hw_wd[fbase + 5'd2] = ar_res[31:16];
			hw_we[fbase + 5'd3] = 1'b1;
			hw_wd[fbase + 5'd3] = ar_res[15:0];
		end
	end

	// ****************************************************************
	// assertions
	// ****************************************************************

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_filt(int j);
		ar_done && !loop_job && job_q == 3'(j) && !wr |=>
			{regs_q[3 + 4 * j + 2], regs_q[3 + 4 * j + 3]} == $past(ar_res);
	endproperty

	AST_BUS_READY: assert property (setup |=> pready ##1 !pready)
		else $error("pready not a one-cycle answer after setup");
	AST_ANGLE_RUN: assert property (trig_go |=> cor_busy ##[1:20] cor_done)
		else $error("trig unit did not finish");
	AST_RES_ONE: assert property (cor_done && !wr |=> regs_q[1] == $past(cor_one))
		else $error("result one not stored");
	AST_RES_TWO: assert property (cor_done && !wr |=> regs_q[2] == $past(cor_two))
		else $error("result two not stored");
	AST_FILT0_STATE: assert property (p_filt(0))
		else $error("filter 0 state not updated");
	AST_FILT1_STATE: assert property (p_filt(1))
		else $error("filter 1 state not updated");
	AST_FILT2_STATE: assert property (p_filt(2))
		else $error("filter 2 state not updated");
	AST_FILT3_STATE: assert property (p_filt(3))
		else $error("filter 3 state not updated");
	AST_JOB_ONE_CYCLE: assert property (ar_go |=> ar_done ##1 seq_q == MSU_SEQ_IDLE)
		else $error("arith step not one cycle");
	AST_LOOP_PREV: assert property (ar_done && loop_job && !wr |=>
			regs_q[20] == $past(regs_q[21]))
		else $error("previous error not shifted");
	AST_LOOP_HALVES: assert property (ar_done && loop_job && !wr |=>
			{regs_q[23], regs_q[24]} == $past(ar_res))
		else $error("loop output halves wrong");
	AST_LOOP_CLAMP: assert property (ar_done && loop_job && !wr &&
			signed'(regs_q[25]) >= signed'(regs_q[26]) |=>
			signed'(regs_q[23]) <= signed'(regs_q[25]) &&
			signed'(regs_q[23]) >= signed'(regs_q[26]))
		else $error("loop output outside limits");
	AST_BYTE_LANE: assert property (wr && hit && !wide && pstrb == 4'h1 && !hw_we[slot] |=>
			regs_q[$past(slot)][15:8] == $past(regs_q[slot][15:8]))
		else $error("unwritten byte lane changed");

	COV_SINCOS: cover property (trig_go && !pwdata[1] ##[1:20] cor_done);
	COV_ATAN: cover property (trig_go && pwdata[1] ##[1:20] cor_done);
	COV_FILTER: cover property (ar_done && !loop_job);
	COV_LOOP: cover property (ar_done && loop_job);
endmodule // msu_top

// ### tb/msu_apb_bfm.sv
// msu_apb_bfm: APB master standing in for the processor core
// assumes: tb_top holds fail_count and print_verdict
module msu_apb_bfm (
	input  wire logic        pclk,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [13:0]      paddr,
	output logic [31:0]      pwdata,
	output logic [3:0]       pstrb,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] rdat;
	logic        rerr;

	// bus idle from time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 14'h0000;
		pwdata = 32'h0000_0000;
		pstrb = 4'h0;
	end

	// one transfer; the request stands until pready is seen at an edge
	task automatic xfer(input logic wr, input logic [11:0] ix, input logic [31:0] d,
		input logic [3:0] s);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {ix, 2'b00};
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		for (n = 0; n < 16 && pready !== 1'b1; n++)
			@(posedge pclk);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			$display("[FAIL] %0t no pready", $time);
			tb_top.fail_count++;
			tb_top.print_verdict();
		end
	endtask
endmodule // msu_apb_bfm

// ### tb/tb_top.sv
// tb_top: register, filter, loop and trig scenarios over APB
// assumes: msu_top with ADDR_W 14, zero wait states
`include "msu_cfg.svh"
module tb_top import msu_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [13:0] paddr;
	logic [31:0] pwdata;
	logic [3:0]  pstrb;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	int          fail_count;
	int          n_checks;
	int          i;
	logic [31:0] d;
	logic [11:0] rix [23] = '{`MSU_IX_ANGLE, `MSU_IX_RES1, `MSU_IX_RES2, `MSU_IX_F3_GAIN,
		`MSU_IX_F3_IN, `MSU_IX_F3_ST, `MSU_IX_F2_GAIN, `MSU_IX_F2_IN, `MSU_IX_F2_ST,
		`MSU_IX_L0_KP, `MSU_IX_L0_EK1, `MSU_IX_L0_EK, `MSU_IX_L0_KI, `MSU_IX_L0_UH,
		`MSU_IX_L0_UL, `MSU_IX_L0_MAX, `MSU_IX_L0_MIN, `MSU_IX_F1_GAIN, `MSU_IX_F1_IN,
		`MSU_IX_F1_ST, `MSU_IX_F0_GAIN, `MSU_IX_F0_IN, `MSU_IX_F0_ST};
	// gain index per filter; sample is +2, state +4
	logic [11:0] fb [4] = '{`MSU_IX_F0_GAIN, `MSU_IX_F1_GAIN, `MSU_IX_F2_GAIN, `MSU_IX_F3_GAIN};

	// ****************************************
	// clock, design and bus master
	// ****************************************
	initial pclk = 1'b0;
	always #2 pclk = ~pclk;

	msu_top #(.ADDR_W(14)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr));
	msu_apb_bfm bfm_u (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));

	// comparison, access and wait helpers
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [11:0] ix, input logic [31:0] v);
		bfm_u.xfer(1'b1, ix, v, 4'hf);
	endtask
	task automatic rd_chk(input logic [11:0] ix, input logic [31:0] exp);
		bfm_u.xfer(1'b0, ix, 32'h0, 4'h0);
		check(bfm_u.rdat, exp);
	endtask
	// cordic results carry rounding, so a small window is accepted
	task automatic near(input logic [11:0] ix, input logic [15:0] exp);
		logic [15:0] e;
		bfm_u.xfer(1'b0, ix, 32'h0, 4'h0);
		e = bfm_u.rdat[15:0] - exp;
		check({31'h0, (e < 16'h0040 || e > 16'hffc0)}, 32'h1);
	endtask
	// poll status until the masked busy bits drop
	task automatic wait_idle(input logic [31:0] m);
		int n;
		for (n = 0; n < 50; n++) begin
			bfm_u.xfer(1'b0, `MSU_IX_STAT, 32'h0, 4'h0);
			if ((bfm_u.rdat & m) === 32'h0)
				break;
		end
		if (n == 50) begin
			fail_count++;
			$display("[FAIL] %0t status stuck", $time);
			print_verdict();
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		fail_count = 0;
		n_checks = 0;
		presetn = 1'b0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		foreach (rix[k]) rd_chk(rix[k], 32'h0);
		// all written first, then read, so aliased slots show up
		for (i = 0; i < 23; i++) wr(rix[i], 32'hc3c3_5a10 + i);
		for (i = 0; i < 23; i++) begin
			d = 32'hc3c3_5a10 + i;
			if (rix[i] != `MSU_IX_F0_ST && rix[i] != `MSU_IX_F1_ST &&
				rix[i] != `MSU_IX_F2_ST && rix[i] != `MSU_IX_F3_ST)
				d[31:16] = 16'h0000;
			rd_chk(rix[i], d);
		end
		wr(`MSU_IX_F0_ST, 32'h1122_3344);
		bfm_u.xfer(1'b1, `MSU_IX_F0_ST, 32'haabb_ccdd, 4'h4);
		rd_chk(`MSU_IX_F0_ST, 32'h11bb_3344);
		// a single low lane on a half-word register leaves its high byte alone
		bfm_u.xfer(1'b1, `MSU_IX_F0_GAIN, 32'h0000_77ee, 4'h1);
		rd_chk(`MSU_IX_F0_GAIN, 32'h0000_5aee);
		bfm_u.xfer(1'b0, 12'h100, 32'h0, 4'h0);
		check({bfm_u.rerr, bfm_u.rdat[30:0]}, 32'h8000_0000);
		// software loads previous outputs, then one control write queues all four filters
		for (i = 0; i < 4; i++) begin
			wr(fb[i], 32'h0000_0100);
			wr(fb[i] + 12'h002, 32'h0000_0015 + i);
			wr(fb[i] + 12'h004, 32'h0005_0000 + i);
		end
		bfm_u.xfer(1'b1, `MSU_IX_CTL, 32'h0000_003c, 4'h1);
		wait_idle(32'h0000_003e);
		for (i = 0; i < 4; i++)
			rd_chk(fb[i] + 12'h004, 32'h0005_2000 + 32'h201 * i);
		// loop step inside limits, then a step driven into the ceiling
		wr(`MSU_IX_L0_KP, 32'h10);
		wr(`MSU_IX_L0_KI, 32'h8);
		wr(`MSU_IX_L0_EK, 32'h20);
		wr(`MSU_IX_L0_EK1, 32'h10);
		wr(`MSU_IX_L0_MAX, 32'h100);
		wr(`MSU_IX_L0_MIN, 32'h0);
		wr(`MSU_IX_L0_UH, 32'h0);
		wr(`MSU_IX_L0_UL, 32'h0);
		bfm_u.xfer(1'b1, `MSU_IX_CTL, 32'h0000_0040, 4'h1);
		wait_idle(32'h0000_003e);
		rd_chk(`MSU_IX_L0_UH, 32'h0);
		rd_chk(`MSU_IX_L0_UL, 32'h400);
		rd_chk(`MSU_IX_L0_EK1, 32'h20);
		wr(`MSU_IX_L0_KI, 32'h7000);
		wr(`MSU_IX_L0_MAX, 32'h10);
		bfm_u.xfer(1'b1, `MSU_IX_CTL, 32'h0000_0040, 4'h1);
		wait_idle(32'h0000_003e);
		rd_chk(`MSU_IX_L0_UH, 32'h10);
		rd_chk(`MSU_IX_L0_UL, 32'h0);
		// sine/cosine at a quarter turn, then arctangent of a vector on the x axis
		wr(`MSU_IX_ANGLE, 32'h4000);
		bfm_u.xfer(1'b1, `MSU_IX_CTL, 32'h0000_0001, 4'h1);
		rd_chk(`MSU_IX_STAT, 32'h1);
		wait_idle(32'h1);
		near(`MSU_IX_RES1, 16'h0000);
		near(`MSU_IX_RES2, 16'h7fff);
		wr(`MSU_IX_RES1, 32'h4000);
		wr(`MSU_IX_RES2, 32'h0);
		bfm_u.xfer(1'b1, `MSU_IX_CTL, 32'h0000_0003, 4'h1);
		wait_idle(32'h1);
		rd_chk(`MSU_IX_CTL, 32'h2);
		near(`MSU_IX_RES1, 16'h4000);
		near(`MSU_IX_RES2, 16'h0000);
		print_verdict();
	end
endmodule // tb_top
